// file: inc/mpd_pkg.sv
// Function
// - enable rising edge queues the message and requests it on the display
// - priority runs 1 lowest to 32 highest, larger is more urgent
// - pending output is high exactly while the message stays queued
// - without acknowledge, enable falling edge removes the message
// - with acknowledge, message stays after enable drops until OK is pressed while it is shown
// - OK is ignored while that message's enable is still high
// - with nothing shown, the display takes the highest-priority queued message
// - a new trigger takes the display only with strictly higher priority
// - when the shown message leaves, show the best one still queued
// - up and down keys step the display through the queued messages
// - up to 64 independent message instances
// - enable rising edge captures time of day and date for that instance
// - live time and date on the display refresh every cycle
// - triggering and display work only in RUN mode
// - per-instance setup holds priority, acknowledge setting and destination
// - a message has at most four text lines
package mpd_pkg;
  localparam int NUM_MSG_DEF = 64;
  localparam int IDX_W = 6;
  localparam int PRIO_W = 6;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int MAX_LINES = 4;
  localparam logic [PRIO_W-1:0] PRIO_MIN = 6'h01;
  localparam logic [PRIO_W-1:0] PRIO_MAX = 6'h20;
  localparam logic [PRIO_W-1:0] PRIO_RST = 6'h01;
  // register word addresses
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 9'h000;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 9'h001;
  localparam logic [ADDR_W-1:0] ADDR_SHOWN = 9'h002;
  localparam logic [ADDR_W-1:0] ADDR_PEND_LO = 9'h003;
  localparam logic [ADDR_W-1:0] ADDR_PEND_HI = 9'h004;
  localparam int CFG_BASE_BIT = 8;
  // config word fields
  localparam int CFG_PRIO_LSB = 0;
  localparam int CFG_ACK_BIT = 8;
  localparam int CFG_DEST_LSB = 12;
  localparam int CFG_LINES_LSB = 16;
  // shown word fields
  localparam int SHOWN_IDX_LSB = 0;
  localparam int SHOWN_VALID_BIT = 8;
  // event bits
  localparam int EV_SHOW = 0;
  localparam int EV_ACK = 1;
  localparam int EV_DROP = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  // key bits
  localparam int KEY_OK = 0;
  localparam int KEY_UP = 1;
  localparam int KEY_DOWN = 2;
  localparam int KEY_W = 3;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } mpd_time_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
  } mpd_date_t;

  typedef struct packed {
    logic [PRIO_W-1:0] prio;
    logic ackReq;
    logic [1:0] dest;
    logic [1:0] lines;
  } mpd_cfg_t;

  localparam mpd_cfg_t CFG_RST = '{prio: PRIO_RST, ackReq: 1'b0, dest: 2'h0, lines: 2'h3};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wrEn;
    logic rdEn;
  } mpd_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] index;
    mpd_cfg_t cfg;
    mpd_time_t trigTime;
    mpd_date_t trigDate;
    mpd_time_t liveTime;
    mpd_date_t liveDate;
  } mpd_view_t;
endpackage

// file: rtl/mpd_message_display.sv
`timescale 1ns/1ps
module mpd_message_display #(
  parameter int NUM_MSG = mpd_pkg::NUM_MSG_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire mpd_pkg::mpd_bus_req_t busReq,
  output logic [mpd_pkg::DATA_W-1:0] rdData,
  input wire logic runMode,
  input wire logic [NUM_MSG-1:0] msgEnable,
  input wire logic [mpd_pkg::KEY_W-1:0] keyPins,
  input wire mpd_pkg::mpd_time_t timeOfDay,
  input wire mpd_pkg::mpd_date_t calDate,
  output logic [NUM_MSG-1:0] msgPending,
  output mpd_pkg::mpd_view_t view,
  output logic irq
);
  import mpd_pkg::*;

  // keypad: three flops, a change counts once the last two agree
  logic [KEY_W-1:0] keyS1Reg, keyS2Reg, keyS3Reg, keyStableReg, keyPressReg;
  logic [KEY_W-1:0] keyStableNext;
  genvar k;
  generate
    for (k = 0; k < KEY_W; k++) begin : gKey
      assign keyStableNext[k] = (keyS2Reg[k] == keyS3Reg[k]) ? keyS3Reg[k] : keyStableReg[k];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyS1Reg <= '0;
      keyS2Reg <= '0;
      keyS3Reg <= '0;
      keyStableReg <= '0;
      keyPressReg <= '0;
    end else begin
      keyS1Reg <= keyPins;
      keyS2Reg <= keyS1Reg;
      keyS3Reg <= keyS2Reg;
      keyStableReg <= keyStableNext;
      keyPressReg <= keyStableNext & ~keyStableReg;
    end
  end

  wire okPress = keyPressReg[KEY_OK];
  wire upPress = keyPressReg[KEY_UP];
  wire downPress = keyPressReg[KEY_DOWN];

  // register bus decode
  wire cfgHit = busReq.addr[CFG_BASE_BIT] &&
                ({1'b0, busReq.addr[CFG_BASE_BIT-1:0]} < 9'(NUM_MSG));
  wire [IDX_W-1:0] cfgIdx = busReq.addr[IDX_W-1:0];
  wire cfgWr = busReq.wrEn && cfgHit;
  wire [PRIO_W-1:0] wrPrioRaw = busReq.wrData[CFG_PRIO_LSB +: PRIO_W];
  // out-of-range priorities are clamped rather than stored, so the compare never sees 0
  wire [PRIO_W-1:0] wrPrio = (wrPrioRaw < PRIO_MIN) ? PRIO_MIN :
                             (wrPrioRaw > PRIO_MAX) ? PRIO_MAX : wrPrioRaw;
  wire mpd_cfg_t wrCfg = '{prio: wrPrio, ackReq: busReq.wrData[CFG_ACK_BIT],
                           dest: busReq.wrData[CFG_DEST_LSB +: 2],
                           lines: busReq.wrData[CFG_LINES_LSB +: 2]};

  // per-instance state
  mpd_cfg_t cfgReg [NUM_MSG];
  mpd_time_t stampTimeReg [NUM_MSG];
  mpd_date_t stampDateReg [NUM_MSG];
  logic [NUM_MSG-1:0] queuedReg, enPrevReg, queuedNext;
  logic [NUM_MSG-1:0] riseVec, fallDropVec, ackVec, ackBlockVec;
  logic ackPulse;

  genvar i;
  generate
    for (i = 0; i < NUM_MSG; i++) begin : gMsg
      wire isShown = view.valid && (view.index == IDX_W'(i));
      assign riseVec[i] = runMode && msgEnable[i] && !enPrevReg[i];
      assign fallDropVec[i] = runMode && !msgEnable[i] && enPrevReg[i] &&
                              !cfgReg[i].ackReq && queuedReg[i];
      assign ackBlockVec[i] = okPress && isShown && msgEnable[i];
      assign ackVec[i] = okPress && isShown && cfgReg[i].ackReq &&
                         !msgEnable[i] && queuedReg[i];
      assign queuedNext[i] = runMode && (riseVec[i] ||
                             (queuedReg[i] && !fallDropVec[i] && !ackVec[i]));

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cfgReg[i] <= CFG_RST;
          stampTimeReg[i] <= '0;
          stampDateReg[i] <= '0;
          queuedReg[i] <= 1'b0;
          enPrevReg[i] <= 1'b0;
        end else begin
          if (cfgWr && (cfgIdx == IDX_W'(i))) begin
            cfgReg[i] <= wrCfg;
          end
          if (riseVec[i]) begin
            stampTimeReg[i] <= timeOfDay;
            stampDateReg[i] <= calDate;
          end
          queuedReg[i] <= queuedNext[i];
          enPrevReg[i] <= msgEnable[i];
        end
      end

      // checked per instance so that every trigger the bench makes is covered
      AST_STAMP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        riseVec[i] |=> stampTimeReg[i] == $past(timeOfDay) &&
                       stampDateReg[i] == $past(calDate))
        else $error("trigger stamp not captured");
    end
  endgenerate

  assign ackPulse = |ackVec;
  assign msgPending = queuedReg;

  // priority search: strict compare keeps the lowest index on equal priority
  logic [IDX_W-1:0] bestIdx, riseIdx, aboveIdx, firstIdx, belowIdx, lastIdx;
  logic [PRIO_W-1:0] bestPrio, risePrio;
  logic aboveHit, belowHit;
  always_comb begin
    bestIdx = '0;
    bestPrio = '0;
    riseIdx = '0;
    risePrio = '0;
    aboveIdx = '0;
    aboveHit = 1'b0;
    firstIdx = '0;
    belowIdx = '0;
    belowHit = 1'b0;
    lastIdx = '0;
    for (int n = 0; n < NUM_MSG; n++) begin
      if (queuedNext[n] && cfgReg[n].prio > bestPrio) begin
        bestPrio = cfgReg[n].prio;
        bestIdx = IDX_W'(n);
      end
      if (riseVec[n] && cfgReg[n].prio > risePrio) begin
        risePrio = cfgReg[n].prio;
        riseIdx = IDX_W'(n);
      end
    end
    for (int n = NUM_MSG - 1; n >= 0; n--) begin
      if (queuedNext[n]) begin
        firstIdx = IDX_W'(n);
        if (IDX_W'(n) > view.index) begin
          aboveIdx = IDX_W'(n);
          aboveHit = 1'b1;
        end
      end
    end
    for (int n = 0; n < NUM_MSG; n++) begin
      if (queuedNext[n]) begin
        lastIdx = IDX_W'(n);
        if (IDX_W'(n) < view.index) begin
          belowIdx = IDX_W'(n);
          belowHit = 1'b1;
        end
      end
    end
  end

  wire anyNext = |queuedNext;
  wire shownGone = !view.valid || !queuedNext[view.index];
  wire riseWins = (|riseVec) && (risePrio > cfgReg[view.index].prio);
  wire [IDX_W-1:0] upIdx = aboveHit ? aboveIdx : firstIdx;
  wire [IDX_W-1:0] downIdx = belowHit ? belowIdx : lastIdx;
  // stepping only moves among queued entries, wrapping at either end
  wire [IDX_W-1:0] nextIdx = shownGone ? bestIdx :
                             riseWins ? riseIdx :
                             upPress ? upIdx :
                             downPress ? downIdx : view.index;
  wire nextValid = runMode && anyNext;
  wire showEvent = nextValid && (!view.valid || nextIdx != view.index);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      view <= '0;
    end else begin
      view.valid <= nextValid;
      view.index <= nextValid ? nextIdx : '0;
      view.cfg <= cfgReg[nextIdx];
      view.trigTime <= stampTimeReg[nextIdx];
      view.trigDate <= stampDateReg[nextIdx];
      view.liveTime <= timeOfDay;
      view.liveDate <= calDate;
    end
  end

  // interrupt status, set wins over a write-one clear in the same cycle
  logic [EV_W-1:0] statusReg, maskReg;
  wire [EV_W-1:0] evSet = {|fallDropVec, ackPulse, showEvent};
  wire statusWr = busReq.wrEn && (busReq.addr == ADDR_STATUS);
  wire maskWr = busReq.wrEn && (busReq.addr == ADDR_MASK);
  wire [EV_W-1:0] statusNext = evSet |
                               (statusReg & ~(statusWr ? busReq.wrData[EV_W-1:0] : '0));

  logic [DATA_W-1:0] cfgRdWord, rdMux;
  always_comb begin
    cfgRdWord = '0;
    cfgRdWord[CFG_PRIO_LSB +: PRIO_W] = cfgReg[cfgIdx].prio;
    cfgRdWord[CFG_ACK_BIT] = cfgReg[cfgIdx].ackReq;
    cfgRdWord[CFG_DEST_LSB +: 2] = cfgReg[cfgIdx].dest;
    cfgRdWord[CFG_LINES_LSB +: 2] = cfgReg[cfgIdx].lines;
  end

  wire [63:0] pendWide = 64'(queuedReg);
  assign rdMux = cfgHit ? cfgRdWord :
                 (busReq.addr == ADDR_STATUS) ? DATA_W'(statusReg) :
                 (busReq.addr == ADDR_MASK) ? DATA_W'(maskReg) :
                 (busReq.addr == ADDR_SHOWN) ? DATA_W'({view.valid, 2'h0, view.index}) :
                 (busReq.addr == ADDR_PEND_LO) ? pendWide[31:0] :
                 (busReq.addr == ADDR_PEND_HI) ? pendWide[63:32] : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      statusReg <= '0;
      maskReg <= MASK_RST;
      rdData <= '0;
      irq <= 1'b0;
    end else begin
      statusReg <= statusNext;
      if (maskWr) begin
        maskReg <= busReq.wrData[EV_W-1:0];
      end
      rdData <= busReq.rdEn ? rdMux : '0;
      irq <= |(statusNext & (maskWr ? busReq.wrData[EV_W-1:0] : maskReg));
    end
  end

  // checks
  logic [NUM_MSG-1:0] shownOneHot;
  assign shownOneHot = view.valid ? (NUM_MSG'(1) << view.index) : '0;

  AST_RISE_QUEUES: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (riseVec != '0) |=> ((msgPending & $past(riseVec)) == $past(riseVec)))
    else $error("triggered message not queued");

  AST_PRIO_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    view.valid |-> (view.cfg.prio >= PRIO_MIN && view.cfg.prio <= PRIO_MAX))
    else $error("shown priority out of range");

  AST_SHOWN_PENDING: assert property (@(posedge sys_clk) disable iff (!rst_n)
    view.valid |-> msgPending[view.index])
    else $error("shown message not pending");

  AST_FALL_DROPS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fallDropVec != '0) |=> ((msgPending & $past(fallDropVec)) == '0))
    else $error("falling enable did not drop message");

  AST_ACK_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ackBlockVec != '0) && runMode |=> ((msgPending & $past(ackBlockVec)) != '0))
    else $error("acknowledge accepted while enable high");

  AST_SHOW_BEST: assert property (@(posedge sys_clk) disable iff (!rst_n)
    shownGone && nextValid |=> view.valid && view.cfg.prio == $past(bestPrio))
    else $error("fallback did not pick best priority");

  AST_NEW_WINS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!shownGone && riseWins) |=> view.index == $past(riseIdx))
    else $error("higher new message not shown");

  AST_ACK_ONLY_SHOWN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ackPulse && (riseVec == '0) && (fallDropVec == '0) && runMode
    |=> (($past(msgPending) & ~msgPending) == $past(shownOneHot)))
    else $error("acknowledge touched another message");

  AST_NO_RUN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !runMode |=> !view.valid && msgPending == '0)
    else $error("activity outside run mode");

  AST_LIVE_TIME: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> view.liveTime == $past(timeOfDay))
    else $error("live time stale");

  COV_ACK: cover property (@(posedge sys_clk) disable iff (!rst_n) ackPulse);
  COV_PREEMPT: cover property (@(posedge sys_clk) disable iff (!rst_n)
    !shownGone && riseWins);
  COV_STEP: cover property (@(posedge sys_clk) disable iff (!rst_n)
    upPress && view.valid ##1 view.valid);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (!rst_n) irq);
endmodule // mpd_message_display

// file: test/mpd_keypad_model.sv
`timescale 1ns/1ps
module mpd_keypad_model #(
  parameter int HOLD = 8
) (
  input wire logic sys_clk,
  input wire logic [mpd_pkg::KEY_W-1:0] pressReq,
  output logic [mpd_pkg::KEY_W-1:0] keyPins
);
  import mpd_pkg::*;
  int holdCnt = 0;
  // a press outlasts the pin synchroniser; pins idle low between presses
  always @(posedge sys_clk) begin
    if (pressReq != '0) begin
      keyPins <= pressReq;
      holdCnt <= HOLD;
    end else if (holdCnt > 1) begin
      holdCnt <= holdCnt - 1;
    end else begin
      holdCnt <= 0;
      keyPins <= '0;
    end
  end
endmodule // mpd_keypad_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import mpd_pkg::*;
  logic sys_clk;
  logic rst_n;
  mpd_bus_req_t busReq;
  logic [DATA_W-1:0] rdData;
  logic runMode;
  logic [63:0] msgEnable;
  logic [KEY_W-1:0] keyPins;
  logic [KEY_W-1:0] keyReq;
  mpd_time_t timeOfDay;
  mpd_date_t calDate;
  logic [63:0] msgPending;
  mpd_view_t view;
  logic irq;
  int err_total = 0;
  int samples_checked = 0;
  int seed = 32'h084baf03;
  logic [31:0] expQ[$];
  logic [31:0] expNow;
  logic [31:0] rnd;
  logic rdSeen = 1'b0;
  mpd_time_t t1;
  mpd_date_t d1;

  mpd_message_display #(.NUM_MSG(64)) mpd_message_display_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .busReq(busReq), .rdData(rdData), .runMode(runMode), .msgEnable(msgEnable),
    .keyPins(keyPins), .timeOfDay(timeOfDay), .calDate(calDate), .msgPending(msgPending),
    .view(view), .irq(irq));
  mpd_keypad_model mpd_keypad_model_i (.sys_clk(sys_clk), .pressReq(keyReq), .keyPins(keyPins));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rdSeen) begin
      expNow = expQ.pop_front();
      chk(rdData, expNow);
    end
    rdSeen <= busReq.rdEn;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    busReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(posedge sys_clk);
    busReq.wrEn <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    busReq <= '{addr: a, wrData: 32'h0, wrEn: 1'b0, rdEn: 1'b1};
    @(posedge sys_clk);
    busReq.rdEn <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic en(input int n, input logic v);
    msgEnable[n] <= v;
    repeat (4) @(posedge sys_clk);
  endtask

  // keys pass a synchroniser, so allow generous settling
  task automatic press(input int k);
    keyReq[k] <= 1'b1;
    @(posedge sys_clk);
    keyReq[k] <= 1'b0;
    repeat (20) @(posedge sys_clk);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk);
    err_total++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    busReq = '0;
    runMode = 1'b1;
    msgEnable = '0;
    keyReq = '0;
    timeOfDay = '0;
    calDate = '0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_MASK, 32'h0);
    rd(ADDR_PEND_LO, 32'h0);
    rd(9'h100, 32'h00030001);
    wr(9'h005, 32'hffffffff);
    rd(9'h005, 32'h0);
    rd(9'h140, 32'h0);
    wr(9'h103, 32'h00031005);
    wr(9'h107, 32'h00030109);
    wr(9'h102, 32'h00030101);
    wr(9'h10a, 32'h00030028);
    wr(9'h10b, 32'h00030000);
    rd(9'h103, 32'h00031005);
    rd(9'h10a, 32'h00030020);
    rd(9'h10b, 32'h00030001);
    done("registers");
    rnd = $random(seed);
    t1 = rnd[16:0];
    rnd = $random(seed);
    d1 = rnd[15:0];
    timeOfDay <= t1;
    calDate <= d1;
    @(posedge sys_clk);
    en(3, 1'b1);
    rd(ADDR_SHOWN, 32'h103);
    rd(ADDR_PEND_LO, 32'h8);
    rd(ADDR_STATUS, 32'h1);
    chk(32'(irq), 32'h0);
    wr(ADDR_MASK, 32'h1);
    chk(32'(irq), 32'h1);
    wr(ADDR_STATUS, 32'h1);
    chk(32'(irq), 32'h0);
    rnd = $random(seed);
    timeOfDay <= rnd[16:0];
    repeat (3) @(posedge sys_clk);
    chk(32'(view.trigTime), 32'(t1));
    chk(32'(view.trigDate), 32'(d1));
    chk(32'(view.liveTime), 32'(timeOfDay));
    chk(32'(view.liveDate), 32'(calDate));
    chk(32'(view.cfg), 32'({6'h05, 1'b0, 2'h1, 2'h3}));
    chk(32'({view.valid, view.index}), 32'h43);
    done("trigger");
    en(7, 1'b1);
    rd(ADDR_SHOWN, 32'h107);
    en(2, 1'b1);
    rd(ADDR_SHOWN, 32'h107);
    rd(ADDR_PEND_LO, 32'h8c);
    press(KEY_OK);
    rd(ADDR_SHOWN, 32'h107);
    en(7, 1'b0);
    en(2, 1'b0);
    rd(ADDR_SHOWN, 32'h107);
    rd(ADDR_PEND_LO, 32'h8c);
    press(KEY_OK);
    rd(ADDR_SHOWN, 32'h103);
    rd(ADDR_PEND_LO, 32'h0c);
    press(KEY_UP);
    rd(ADDR_SHOWN, 32'h102);
    press(KEY_DOWN);
    rd(ADDR_SHOWN, 32'h103);
    en(3, 1'b0);
    rd(ADDR_PEND_LO, 32'h4);
    rd(ADDR_SHOWN, 32'h102);
    rd(ADDR_STATUS, 32'h7);
    done("display");
    en(40, 1'b1);
    rd(ADDR_PEND_HI, 32'h100);
    chk(32'(msgPending[40]), 32'h1);
    runMode <= 1'b0;
    repeat (2) @(posedge sys_clk);
    en(40, 1'b0);
    en(5, 1'b1);
    rd(ADDR_PEND_LO, 32'h0);
    rd(ADDR_PEND_HI, 32'h0);
    rd(ADDR_SHOWN, 32'h0);
    runMode <= 1'b1;
    en(5, 1'b0);
    done("run mode");
    results();
  end
endmodule // testbench
